// ==== rtl/spm_cfg.svh ====
// Offsets, field positions, reset values and counts for the strap and pin mux block
// Assumes inclusion by bare name from the package and design files
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH
// Register byte offsets on APB
`define SPM_OFS_CTRL 12'h000
`define SPM_OFS_STRAP 12'h004
`define SPM_OFS_GPIO_DIR 12'h008
`define SPM_OFS_GPIO_OUT 12'h00C
`define SPM_OFS_GPIO_IN 12'h010
`define SPM_OFS_GPIO_ALT 12'h014
`define SPM_OFS_PORT_STS 12'h018
`define SPM_OFS_MGMT 12'h01C
// Control register field positions
`define SPM_CTRL_UP_OVR_EN 0
`define SPM_CTRL_TP_OVR_EN 1
`define SPM_CTRL_NTP_OVR_EN 2
`define SPM_CTRL_UP_REV 4
`define SPM_CTRL_TP_REV 5
`define SPM_CTRL_NTP_REV 6
`define SPM_CTRL_TP_RST 8
`define SPM_CTRL_NTP_RST 9
// Management bus request bit
`define SPM_MGMT_BUSY 0
// Reset values
`define SPM_CTRL_RST 32'h0000_0000
`define SPM_GPIO_RST 8'h00
// Pins that own an alternate function
`define SPM_ALT_CAPABLE 8'h3F
// Failover switch modes
`define SPM_MODE_FAILOVER 4'h4
`define SPM_MODE_FAILOVER_EE 4'h5
// Reference clock frequencies in MHz
`define SPM_REFCLK_MHZ_0 100
`define SPM_REFCLK_MHZ_1 125
// Master bus clock divider terminal count, one less than the half period in core cycles
`define SPM_MCLK_HALF 8'h7C
`endif

// ==== rtl/spm_pkg.sv ====
// Types shared by the strap and pin mux block
// Assumes spm_cfg.svh supplies the numeric constants
`include "spm_cfg.svh"
package spm_pkg;
    // Straps captured during reset
    typedef struct packed {
        logic up_rev;
        logic tp_rev;
        logic ntp_rev;
        logic refclk_sel;
        logic [3:0] eeprom_addr;
        logic [3:0] slave_addr;
        logic [3:0] mode;
    } spm_strap_t;
    // Two-signal GPIO pin drive group
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } spm_gpio_drv_t;
    // Whole state of the block
    typedef struct packed {
        spm_strap_t strap;
        logic [31:0] ctrl;
        logic [7:0] gpio_dir;
        logic [7:0] gpio_out;
        logic [7:0] gpio_alt;
        logic [7:0] gpio_in_s1;
        logic [7:0] gpio_in_s2;
        logic [7:0] port_s1;
        logic [7:0] port_s2;
        logic mgmt_busy;
        logic [7:0] mclk_cnt;
        logic mclk;
        logic [2:0] lane_rev;
        spm_gpio_drv_t gpio;
        logic [6:0] slave_addr7;
        logic [6:0] eeprom_addr7;
        logic failover;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } spm_state_t;
endpackage : spm_pkg

// ==== rtl/spm_pin_mux.sv ====
// Strap capture, lane reversal, clock select decode and GPIO alternate-function mux
// Assumes straps are stable while rst_n is low and APB master on ref_clk
// What this block does
// - Names ending in _n are asserted low; every other signal is asserted high, except GPIO pins zero to four in alternate mode.
// - The upstream lane-reverse strap reverses that port unless software overrides it.
// - The transparent port lane-reverse strap reverses that port unless its own bit overrides.
// - The non-transparent port lane-reverse strap reverses that port unless its bit overrides.
// - A clock select strap of zero means a 100 MHz reference, one means 125 MHz.
// - EEPROM address bits four to one come from the four master address straps.
// - The master bus clock toggles only while an EEPROM or expander access runs.
// - The slave address bits five and three to one come from the four slave straps.
// - Each of the eight GPIO pins may be a general input or output.
// - Pin zero in alternate mode drives the transparent port reset, low active.
// - Pin one in alternate mode drives the non-transparent port reset, low active.
// - Pins two to four in alternate mode show the three link-up states, low active.
// - Pin five in alternate mode is the failover request input.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "spm_cfg.svh"
module spm_pin_mux (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic up_port_lane_rev_strap,
    input wire logic tp_port_lane_rev_strap,
    input wire logic ntp_port_lane_rev_strap,
    input wire logic refclk_freq_sel,
    input wire logic [3:0] eeprom_addr_straps,
    input wire logic [3:0] slave_addr_straps,
    input wire logic [3:0] switch_mode_straps,
    input wire logic up_link_up,
    input wire logic tp_link_up,
    input wire logic ntp_link_up,
    input wire logic mgmt_access_req,
    input wire logic [7:0] gpio_i,
    output logic [7:0] gpio_o,
    output logic [7:0] gpio_oe,
    output logic [2:0] lane_rev,
    output logic refclk_is_125,
    output logic [6:0] eeprom_addr,
    output logic [6:0] slave_addr,
    output logic master_mgmt_clk,
    output logic failover_request_in
);
    spm_pkg::spm_state_t cur_ff;
    spm_pkg::spm_state_t nxt_st;

    // Byte-lane merge of a write into a register
    function automatic logic [31:0] spm_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction : spm_merge

    // Strap or software override for one port
    function automatic logic spm_rev(input logic strap, input logic en, input logic val);
        return en ? val : strap;
    endfunction : spm_rev

    // Next-state logic
    always_comb
    begin
        nxt_st = cur_ff;
        // Pin inputs pass two flops before use
        nxt_st.gpio_in_s1 = gpio_i;
        nxt_st.gpio_in_s2 = cur_ff.gpio_in_s1;
        nxt_st.port_s1 = {4'h0, mgmt_access_req, ntp_link_up, tp_link_up, up_link_up};
        nxt_st.port_s2 = cur_ff.port_s1;
        nxt_st.pready = 1'b0;
        nxt_st.pslverr = 1'b0;
        // APB slave, one wait state: answer the cycle after the first access cycle
        if (psel && penable && !cur_ff.pready)
        begin
            nxt_st.pready = 1'b1;
            nxt_st.prdata = 32'h0000_0000;
            case (paddr)
                `SPM_OFS_CTRL:
                begin
                    nxt_st.prdata = cur_ff.ctrl & 32'h0000_0377;
                    if (pwrite)
                    begin
                        nxt_st.ctrl = spm_merge(cur_ff.ctrl, pwdata, pstrb) & 32'h0000_0377;
                    end
                end
                `SPM_OFS_STRAP:
                    nxt_st.prdata = {16'h0000, cur_ff.strap};
                `SPM_OFS_GPIO_DIR:
                begin
                    nxt_st.prdata = {24'h00_0000, cur_ff.gpio_dir};
                    if (pwrite && pstrb[0])
                    begin
                        nxt_st.gpio_dir = pwdata[7:0];
                    end
                end
                `SPM_OFS_GPIO_OUT:
                begin
                    nxt_st.prdata = {24'h00_0000, cur_ff.gpio_out};
                    if (pwrite && pstrb[0])
                    begin
                        nxt_st.gpio_out = pwdata[7:0];
                    end
                end
                `SPM_OFS_GPIO_IN:
                    nxt_st.prdata = {24'h00_0000, cur_ff.gpio_in_s2};
                `SPM_OFS_GPIO_ALT:
                begin
                    nxt_st.prdata = {24'h00_0000, cur_ff.gpio_alt};
                    if (pwrite && pstrb[0])
                    begin
                        nxt_st.gpio_alt = pwdata[7:0] & `SPM_ALT_CAPABLE;
                    end
                end
                `SPM_OFS_PORT_STS:
                    nxt_st.prdata = {24'h00_0000, 1'b0, cur_ff.failover, cur_ff.lane_rev,
                                     cur_ff.port_s2[2:0]};
                `SPM_OFS_MGMT:
                    nxt_st.prdata = {31'h0000_0000, cur_ff.mgmt_busy};
                default:
                    nxt_st.pslverr = 1'b1;
            endcase
            if (!pwrite && paddr != `SPM_OFS_CTRL)
            begin
                nxt_st.pslverr = nxt_st.pslverr;
            end
        end
        // Lane reversal from strap or override
        nxt_st.lane_rev[0] = spm_rev(cur_ff.strap.up_rev, cur_ff.ctrl[`SPM_CTRL_UP_OVR_EN],
                                     cur_ff.ctrl[`SPM_CTRL_UP_REV]);
        nxt_st.lane_rev[1] = spm_rev(cur_ff.strap.tp_rev, cur_ff.ctrl[`SPM_CTRL_TP_OVR_EN],
                                     cur_ff.ctrl[`SPM_CTRL_TP_REV]);
        nxt_st.lane_rev[2] = spm_rev(cur_ff.strap.ntp_rev, cur_ff.ctrl[`SPM_CTRL_NTP_OVR_EN],
                                     cur_ff.ctrl[`SPM_CTRL_NTP_REV]);
        // Address forming from straps
        nxt_st.eeprom_addr7 = {2'b10, cur_ff.strap.eeprom_addr, 1'b0};
        nxt_st.slave_addr7 = {1'b1, cur_ff.strap.slave_addr[3], 1'b0,
                              cur_ff.strap.slave_addr[2:0], 1'b0};
        // Master bus clock only during an access
        nxt_st.mgmt_busy = cur_ff.port_s2[3];
        if (cur_ff.mgmt_busy)
        begin
            if (cur_ff.mclk_cnt == `SPM_MCLK_HALF)
            begin
                nxt_st.mclk_cnt = 8'h00;
                nxt_st.mclk = ~cur_ff.mclk;
            end
            else
            begin
                nxt_st.mclk_cnt = cur_ff.mclk_cnt + 8'h01;
            end
        end
        else
        begin
            nxt_st.mclk_cnt = 8'h00;
            nxt_st.mclk = 1'b1;
        end
        // Failover counts only in failover modes
        nxt_st.failover = cur_ff.gpio_alt[5] && cur_ff.gpio_in_s2[5] &&
                          (cur_ff.strap.mode == `SPM_MODE_FAILOVER ||
                           cur_ff.strap.mode == `SPM_MODE_FAILOVER_EE);
        // GPIO output mux
        for (int p = 0; p < 8; p++)
        begin
            nxt_st.gpio.o[p] = cur_ff.gpio_out[p];
            nxt_st.gpio.oe[p] = cur_ff.gpio_dir[p];
        end
        if (cur_ff.gpio_alt[0])
        begin
            nxt_st.gpio.o[0] = ~cur_ff.ctrl[`SPM_CTRL_TP_RST];
            nxt_st.gpio.oe[0] = 1'b1;
        end
        if (cur_ff.gpio_alt[1])
        begin
            nxt_st.gpio.o[1] = ~cur_ff.ctrl[`SPM_CTRL_NTP_RST];
            nxt_st.gpio.oe[1] = 1'b1;
        end
        for (int k = 0; k < 3; k++)
        begin
            if (cur_ff.gpio_alt[2 + k])
            begin
                nxt_st.gpio.o[2 + k] = ~cur_ff.port_s2[k];
                nxt_st.gpio.oe[2 + k] = 1'b1;
            end
        end
        if (cur_ff.gpio_alt[5])
        begin
            nxt_st.gpio.o[5] = 1'b0;
            nxt_st.gpio.oe[5] = 1'b0;
        end
        // Straps sampled while reset is held
        if (!rst_n)
        begin
            nxt_st = '0;
            nxt_st.strap.up_rev = up_port_lane_rev_strap;
            nxt_st.strap.tp_rev = tp_port_lane_rev_strap;
            nxt_st.strap.ntp_rev = ntp_port_lane_rev_strap;
            nxt_st.strap.refclk_sel = refclk_freq_sel;
            nxt_st.strap.eeprom_addr = eeprom_addr_straps;
            nxt_st.strap.slave_addr = slave_addr_straps;
            nxt_st.strap.mode = switch_mode_straps;
            nxt_st.ctrl = `SPM_CTRL_RST;
            nxt_st.gpio_dir = `SPM_GPIO_RST;
            nxt_st.gpio_alt = `SPM_GPIO_RST;
            nxt_st.mclk = 1'b1;
        end
    end

    // State register, synchronous reset folded into next state
    always_ff @(posedge ref_clk)
    begin
        cur_ff <= nxt_st;
    end

    // Outputs straight from flops
    assign prdata = cur_ff.prdata;
    assign pready = cur_ff.pready;
    assign pslverr = cur_ff.pslverr;
    assign gpio_o = cur_ff.gpio.o;
    assign gpio_oe = cur_ff.gpio.oe;
    assign lane_rev = cur_ff.lane_rev;
    assign refclk_is_125 = cur_ff.strap.refclk_sel;
    assign eeprom_addr = cur_ff.eeprom_addr7;
    assign slave_addr = cur_ff.slave_addr7;
    assign master_mgmt_clk = cur_ff.mclk;
    assign failover_request_in = cur_ff.failover;
endmodule : spm_pin_mux

// ==== verification/spm_pin_mux_sva.sv ====
// Port checker for the strap and pin mux block
// Assumes binding to spm_pin_mux, rst_n synchronous and active low
`timescale 1ns/100ps
module spm_pin_mux_sva (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic refclk_freq_sel,
    input wire logic [3:0] eeprom_addr_straps,
    input wire logic [3:0] slave_addr_straps,
    input wire logic [3:0] switch_mode_straps,
    input wire logic mgmt_access_req,
    input wire logic [7:0] gpio_oe,
    input wire logic refclk_is_125,
    input wire logic [6:0] eeprom_addr,
    input wire logic [6:0] slave_addr,
    input wire logic master_mgmt_clk,
    input wire logic failover_request_in
);
    logic [12:0] cap_ff;
    logic [8:0] idle_ff;
    // Straps as last seen in reset, and idle time of the access request
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            cap_ff <= {refclk_freq_sel, eeprom_addr_straps, slave_addr_straps, switch_mode_straps};
        idle_ff <= (!rst_n || mgmt_access_req) ? 9'h000 : idle_ff + 9'(idle_ff < 9'h1FF);
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_slave_addr: assert property (rst_n && $past(rst_n) |->
        slave_addr == {1'b1, cap_ff[7], 1'b0, cap_ff[6:4], 1'b0}) else $error("slave addr");
    a_eeprom_addr: assert property (rst_n && $past(rst_n) |->
        eeprom_addr == {2'b10, cap_ff[11:8], 1'b0}) else $error("eeprom addr");
    a_refclk_sel: assert property (rst_n && $past(rst_n) |->
        refclk_is_125 == cap_ff[12]) else $error("refclk select");
    a_mclk_idle: assert property (idle_ff > 9'd200 |->
        master_mgmt_clk && $stable(master_mgmt_clk)) else $error("mgmt clock not idle");
    a_mclk_hold: assert property ($changed(master_mgmt_clk) && mgmt_access_req |=>
        (!mgmt_access_req || $stable(master_mgmt_clk)) [*8]) else $error("mgmt clock fast");
    a_fo_mode: assert property (failover_request_in |->
        cap_ff[3:0] inside {4'h4, 4'h5}) else $error("failover outside mode");
    a_fo_input: assert property (failover_request_in |-> !gpio_oe[5])
        else $error("failover pin driven");
    a_apb_answer: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
endmodule : spm_pin_mux_sva
bind spm_pin_mux spm_pin_mux_sva spm_pin_mux_sva_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pready(pready), .refclk_freq_sel(refclk_freq_sel),
    .eeprom_addr_straps(eeprom_addr_straps), .slave_addr_straps(slave_addr_straps),
    .switch_mode_straps(switch_mode_straps), .mgmt_access_req(mgmt_access_req),
    .gpio_oe(gpio_oe), .refclk_is_125(refclk_is_125), .eeprom_addr(eeprom_addr),
    .slave_addr(slave_addr), .master_mgmt_clk(master_mgmt_clk),
    .failover_request_in(failover_request_in));

// ==== verification/spm_board_model.sv ====
// Board side of the GPIO pins: external drivers and pull-ups
// Assumes the bench sets which pins the board drives
`timescale 1ns/100ps
module spm_board_model (
    input wire logic [7:0] gpio_o,
    input wire logic [7:0] gpio_oe,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] gpio_i
);
    // Pin level: device drive, else board drive, else pull-up
    always_comb
    begin
        for (int k = 0; k < 8; k++)
            gpio_i[k] = gpio_oe[k] ? gpio_o[k] : (ext_en[k] ? ext_val[k] : 1'b1);
    end
endmodule : spm_board_model

// ==== verification/strap_and_gpio_pin_mux_tb_top.sv ====
// Self-checking bench for the strap and pin mux block
// Assumes 100 MHz core clock and APB access from the bench
`timescale 1ns/100ps
`include "spm_cfg.svh"
module strap_and_gpio_pin_mux_tb_top;
    localparam logic [2:0] LR = 3'b101;
    logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, e, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic us = 0, ts = 0, ns = 0, rs = 0, req = 0, lu = 1, lt = 0, ln = 1;
    logic fo, mc, r125;
    logic [3:0] ee = 4'h0, sv = 4'h0, md = 4'h0;
    logic [7:0] gi, go, goe, xen = 8'h00, xv = 8'h00;
    logic [2:0] lane_rev;
    logic [6:0] ea, sa;
    int err_total = 0, cmp_count = 0, cyc = 0;
    spm_pin_mux spm_pin_mux_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .up_port_lane_rev_strap(us),
        .tp_port_lane_rev_strap(ts), .ntp_port_lane_rev_strap(ns), .refclk_freq_sel(rs),
        .eeprom_addr_straps(ee), .slave_addr_straps(sv), .switch_mode_straps(md),
        .up_link_up(lu), .tp_link_up(lt), .ntp_link_up(ln), .mgmt_access_req(req),
        .gpio_i(gi), .gpio_o(go), .gpio_oe(goe), .lane_rev(lane_rev), .refclk_is_125(r125),
        .eeprom_addr(ea), .slave_addr(sa), .master_mgmt_clk(mc), .failover_request_in(fo));
    spm_board_model spm_board_model_i (.gpio_o(go), .gpio_oe(goe), .ext_en(xen),
        .ext_val(xv), .gpio_i(gi));
    // Clock and hang guard
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            err_total++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x)
        begin
            err_total++;
            $display("mismatch at %0t got %h expected %h", $time, g, x);
        end
    endtask : chk
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1 && n++ < 40);
        // Missing answer counts as a mismatch
        if (pready !== 1'b1)
            err_total++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic do_reset(input logic [3:0] m);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        md <= m;
        ee <= m ^ 4'h9;
        sv <= ~m;
        rs <= m[0];
        {ns, ts, us} <= LR;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask : do_reset
    // Captured straps, then unchanged after the pins move
    task automatic t_straps(input logic [3:0] m);
        chk(32'(goe), 32'h0000_0000);
        apb(1'b0, `SPM_OFS_STRAP, 32'h0000_0000);
        chk(q, 32'({LR[0], LR[1], LR[2], m[0], m ^ 4'h9, ~m, m}));
        for (int i = 0; i < 2; i++)
        begin
            chk(32'(ea), {25'h0, 2'b10, m ^ 4'h9, 1'b0});
            chk(32'(sa), {25'h0, 1'b1, ~m[3], 1'b0, ~m[2:0], 1'b0});
            chk(32'(r125), 32'(m[0]));
            chk(32'(lane_rev), 32'(LR));
            {ee, sv, rs, us} <= ~{ee, sv, rs, us};
            repeat (4) @(posedge ref_clk);
        end
        $display("straps test finished");
    endtask : t_straps
    // Software override of each port's lane order
    task automatic t_lane();
        for (int p = 0; p < 3; p++)
        begin
            apb(1'b1, `SPM_OFS_CTRL, (32'h1 << p) | (32'(!LR[p]) << (p + 4)));
            repeat (3) @(posedge ref_clk);
            chk(32'(lane_rev), 32'(LR ^ (3'b001 << p)));
        end
        $display("lane test finished");
    endtask : t_lane
    // Plain GPIO output then input, then the alternate functions
    task automatic t_gpio();
        apb(1'b1, `SPM_OFS_GPIO_DIR, 32'h0000_00FF);
        apb(1'b1, `SPM_OFS_GPIO_OUT, 32'h0000_00A5);
        repeat (3) @(posedge ref_clk);
        chk({goe, go}, 32'h0000_FFA5);
        apb(1'b1, `SPM_OFS_GPIO_DIR, 32'h0000_0000);
        {xen, xv} <= 16'hFF3C;
        repeat (6) @(posedge ref_clk);
        apb(1'b0, `SPM_OFS_GPIO_IN, 32'h0000_0000);
        chk(q, 32'h0000_003C);
        apb(1'b1, `SPM_OFS_CTRL, 32'h0000_0100);
        apb(1'b1, `SPM_OFS_GPIO_ALT, 32'h0000_00FF);
        apb(1'b0, `SPM_OFS_GPIO_ALT, 32'h0000_0000);
        chk(q, 32'h0000_003F);
        repeat (6) @(posedge ref_clk);
        chk(32'(goe), 32'h0000_001F);
        chk(32'(go[4:0]), 32'h0000_000A);
        chk(32'(fo), 32'h0000_0001);
        apb(1'b0, `SPM_OFS_PORT_STS, 32'h0000_0000);
        chk(q, 32'h0000_006D);
        apb(1'b0, 12'h100, 32'h0000_0000);
        chk({q[30:0], e}, 32'h0000_0001);
        $display("gpio test finished");
    endtask : t_gpio
    // Failover input honoured only in the failover modes
    task automatic t_fo(input logic [3:0] m, input logic x);
        do_reset(m);
        apb(1'b1, `SPM_OFS_GPIO_ALT, 32'h0000_0020);
        repeat (6) @(posedge ref_clk);
        chk(32'(fo), 32'(x));
        $display("failover test finished");
    endtask : t_fo
    // Management clock runs only during an access
    task automatic t_mclk();
        int n;
        logic pv;
        n = 0;
        pv = mc;
        chk(32'(mc), 32'h0000_0001);
        req <= 1'b1;
        repeat (600)
        begin
            @(posedge ref_clk);
            n += int'(mc !== pv);
            pv = mc;
        end
        apb(1'b0, `SPM_OFS_MGMT, 32'h0000_0000);
        chk(q, 32'h0000_0001);
        chk(32'(n >= 4 && n <= 5), 32'h0000_0001);
        req <= 1'b0;
        repeat (260) @(posedge ref_clk);
        chk(32'(mc), 32'h0000_0001);
        $display("mgmt clock test finished");
    endtask : t_mclk
    // Main sequence
    initial
    begin
        do_reset(4'h5);
        t_straps(4'h5);
        t_lane();
        t_gpio();
        t_fo(4'h4, 1'b1);
        t_fo(4'h2, 1'b0);
        t_mclk();
        end_sim();
    end
endmodule : strap_and_gpio_pin_mux_tb_top
